//--- rtl/swc_core.sv
// Switch core: per-port input queues, credit accounting, egress arbitration.
// Assumes port stacks hand over whole TLP descriptors, one per port per cycle.
// How it works
// - Link down on a port discards every queued TLP that came in on that port, except those marked keep.
// - TLPs heading to a port whose link is down are returned as Unsupported Requests.
// - Configuration accesses to a down port's bridge are still queued and executed.
// - Completions marked keep are never discarded, even on link down.
// - At link up each port advertises its configured credits.
// - Downstream ports emit slot power messages at link up, or on slot write while their link is up.
// - Three queues per port: posted 4 KB, non-posted 1 KB, completion 4 KB, 32 TLPs.
// - A queue refuses TLPs when its bytes or descriptors run out.
// - A full egress replay buffer stops all forwarding to that port.
// - Header routing lookup picks the egress, TLP goes into its class queue.
// - TLPs may return to the egress of the port they entered.
// - Only TLPs with enough egress partner credit are forwarded.
// - Cut-through only when ingress width is at least egress width.
// - Per ingress only the oldest TLP is a candidate.
// - Head TLPs older than 50 ms are discarded, except those marked keep.
// - Relaxed TLPs may be passed unless strict ordering is forced.
// - Egress arbiter uses round robin or 32-phase weighted round robin.
// - Default credits: 30 headers, 204 posted/completion data, 30 non-posted data.
// - Bytes per credit: header 20, posted/completion data 16, non-posted data 8.
// - Two header and data credits stay reserved for switch-made TLPs.
`timescale 1ns/1ns
module swc_core #(
  parameter int                        DEPTH     = swc_pkg::DEPTH_DEF,
  parameter logic [swc_pkg::TS_W-1:0]  AGE_LIMIT = swc_pkg::TS_W'(swc_pkg::AGE_TICKS),
  parameter logic [11:0]               TICK      = 12'(swc_pkg::TICK_CYC)
) (
  input  wire logic                                     clk,
  input  wire logic                                     rst_n,
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [7:0]                               paddr,
  input  wire logic [31:0]                              pwdata,
  output wire logic [31:0]                              prdata,
  output wire logic                                     pready,
  output wire logic                                     pslverr,
  input  wire logic [swc_pkg::NPORT-1:0]                link_up,
  input  wire logic [swc_pkg::NPORT-1:0][2:0]           link_width,
  input  wire logic [swc_pkg::NPORT-1:0]                in_valid,
  output logic      [swc_pkg::NPORT-1:0]                in_ready,
  input  wire logic [swc_pkg::NPORT-1:0][1:0]           in_cls,
  input  wire logic [swc_pkg::NPORT-1:0][1:0]           in_key,
  input  wire logic [swc_pkg::NPORT-1:0]                in_bridge,
  input  wire logic [swc_pkg::NPORT-1:0][12:0]          in_len,
  input  wire logic [swc_pkg::NPORT-1:0]                in_ro,
  input  wire logic [swc_pkg::NPORT-1:0]                in_keep,
  input  wire logic [swc_pkg::NPORT-1:0]                in_gen,
  input  wire logic [swc_pkg::NPORT-1:0]                in_done,
  input  wire logic [swc_pkg::NPORT-1:0][7:0]           in_id,
  input  wire logic [swc_pkg::NPORT-1:0]                tail_done,
  input  wire logic [swc_pkg::NPORT-1:0][swc_pkg::NCLS-1:0] e_credit_ok,
  input  wire logic [swc_pkg::NPORT-1:0]                e_replay_full,
  output wire logic [swc_pkg::NPORT-1:0]                e_valid,
  output wire logic [swc_pkg::NPORT-1:0][1:0]           e_src,
  output wire logic [swc_pkg::NPORT-1:0][1:0]           e_cls,
  output wire logic [swc_pkg::NPORT-1:0][12:0]          e_len,
  output wire logic [swc_pkg::NPORT-1:0][7:0]           e_id,
  output wire logic [swc_pkg::NPORT-1:0]                e_keep,
  output wire logic                                     ur_valid,
  output wire logic [1:0]                               ur_src,
  output wire logic [7:0]                               ur_id,
  output wire logic [swc_pkg::NPORT-1:0]                adv_valid,
  output logic      [swc_pkg::NPORT-1:0][swc_pkg::NCLS-1:0][7:0]  adv_hdr,
  output logic      [swc_pkg::NPORT-1:0][swc_pkg::NCLS-1:0][11:0] adv_data,
  output wire logic [swc_pkg::NPORT-1:0]                slot_power_msg,
  output wire logic [swc_pkg::NPORT-1:0][31:0]          slot_cap
);
  import swc_pkg::*;

  localparam int IW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    swc_entry_t [NPORT-1:0][NCLS-1:0][DEPTH-1:0] mem;
    logic [NPORT-1:0][NCLS-1:0][IW-1:0]          rd;
    logic [NPORT-1:0][NCLS-1:0][IW-1:0]          wr;
    logic [NPORT-1:0][NCLS-1:0][CW-1:0]          cnt;
    logic [NPORT-1:0][NCLS-1:0][7:0]             hdr_used;
    logic [NPORT-1:0][NCLS-1:0][11:0]            dat_used;
    logic [NPORT-1:0][1:0]                       last_cls;
    logic [NPORT-1:0]                            link_q;
    logic [11:0]                                 pre;
    logic [TS_W-1:0]                             ts;
    logic [2:0]                                  ctrl;
    logic [7:0]                                  route;
    logic [63:0]                                 wrr;
    logic [NCLS-1:0][NPORT-1:0][19:0]            cred;
    logic [NPORT-1:0][31:0]                      slot;
    logic [NPORT-1:0][1:0]                       rr_last;
    logic [NPORT-1:0][4:0]                       phase;
    logic [NPORT-1:0]                            e_valid;
    logic [NPORT-1:0][1:0]                       e_src;
    logic [NPORT-1:0][1:0]                       e_cls;
    logic [NPORT-1:0][12:0]                      e_len;
    logic [NPORT-1:0][7:0]                       e_id;
    logic [NPORT-1:0]                            e_keep;
    logic                                        ur_valid;
    logic [1:0]                                  ur_src;
    logic [7:0]                                  ur_id;
    logic [NPORT-1:0]                            adv;
    logic [NPORT-1:0]                            spl;
    logic [15:0]                                 drops;
    logic [31:0]                                 prdata;
    logic                                        pslverr;
    logic [NPORT-1:0][NCLS-1:0]                  cr_past;
    logic [NPORT-1:0]                            hs_past;
  } swc_state_t;

  swc_state_t                          s_q;
  swc_state_t                          s_d;
  swc_entry_t [NPORT-1:0][NCLS-1:0]    hd;
  logic [NPORT-1:0][NCLS-1:0]          nonempty;
  logic [NPORT-1:0][NCLS-1:0]          discard;
  logic [NPORT-1:0][NCLS-1:0]          fwd;
  logic [NPORT-1:0][NCLS-1:0]          pop;
  logic [NPORT-1:0][NCLS-1:0][TS_W-1:0] age;
  logic [NPORT-1:0][1:0]               pick_cls;
  logic [NPORT-1:0]                    pick_ok;
  logic [NPORT-1:0]                    ur_path;
  logic [NPORT-1:0]                    fits;
  logic                                reg_hit;
  logic [31:0]                         reg_rdata;

  function automatic logic [11:0] dcred(input logic [1:0] c, input logic [12:0] len);
    logic [16:0] g;
    logic [16:0] t;
    g = (c == CLS_NP) ? GRAN_NP : GRAN_BIG;
    t = ({4'h0, len} + g - 17'h00001) / g;
    return t[11:0];
  endfunction

  // ==========================================================
  // Register read decode
  always_comb
  begin
    logic [1:0] rc;
    logic [1:0] rp;
    rc = 2'(paddr[5:4] - 2'h1);
    rp = paddr[3:2];
    reg_hit = 1'b1;
    reg_rdata = 32'h0;
    if (paddr[1:0] != 2'h0)
      reg_hit = 1'b0;
    else if (paddr == REG_CTRL)
      reg_rdata = {29'h0, s_q.ctrl};
    else if (paddr == REG_ROUTE)
      reg_rdata = {24'h0, s_q.route};
    else if (paddr == REG_WRR0)
      reg_rdata = s_q.wrr[31:0];
    else if (paddr == REG_WRR1)
      reg_rdata = s_q.wrr[63:32];
    else if (paddr >= REG_CRED && paddr < REG_SLOT && 32'(rp) < NPORT)
      reg_rdata = {12'h0, s_q.cred[rc][rp]};
    else if (paddr[7:4] == REG_SLOT[7:4] && 32'(rp) < NPORT)
      reg_rdata = s_q.slot[rp];
    else if (paddr == REG_STAT)
      reg_rdata = {20'h0, s_q.link_q, nonempty};
    else if (paddr == REG_DROPS)
      reg_rdata = {16'h0, s_q.drops};
    else
      reg_hit = 1'b0;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [1:0]  dst;
    logic [1:0]  c;
    logic [1:0]  w;
    logic [11:0] dc;
    logic [7:0]  lim_h;
    logic [11:0] lim_d;
    logic [16:0] bytes;
    logic [16:0] gran;
    logic [TS_W-1:0] best;
    logic        found;
    logic        urtaken;
    logic [2:0]  g;
    int          idx;
    dst = 2'h0; c = 2'h0; w = 2'h0; dc = 12'h0; lim_h = 8'h0; lim_d = 12'h0;
    bytes = 17'h0; gran = 17'h0; best = '0; found = 1'b0; urtaken = 1'b0;
    g = 3'h0; idx = 0;
    s_d = s_q;
    s_d.e_valid = '0;
    s_d.ur_valid = 1'b0;
    s_d.adv = '0;
    s_d.spl = '0;
    s_d.cr_past = e_credit_ok;
    pop = '0;
    // Free-running stamp timer
    if (s_q.pre == TICK - 12'h001)
    begin
      s_d.pre = 12'h0;
      s_d.ts = TS_W'(s_q.ts + 1'b1);
    end
    else
      s_d.pre = 12'(s_q.pre + 1'b1);
    // Queue heads and forwarding eligibility
    for (int p = 0; p < NPORT; p++)
      for (int k = 0; k < NCLS; k++)
      begin
        hd[p][k] = s_q.mem[p][k][s_q.rd[p][k]];
        nonempty[p][k] = (s_q.cnt[p][k] != '0);
        age[p][k] = TS_W'(s_q.ts - hd[p][k].ts);
        discard[p][k] = nonempty[p][k] && !hd[p][k].keep &&
                        (hd[p][k].drop || age[p][k] > AGE_LIMIT);
        dst = hd[p][k].dest;
        fwd[p][k] = nonempty[p][k] && !discard[p][k] && (link_up[p] || hd[p][k].keep) &&
                    32'(dst) < NPORT && e_credit_ok[dst][k] &&
                    !e_replay_full[dst] &&
                    (link_width[p] >= link_width[dst] || hd[p][k].done);
      end
    // Oldest candidate per ingress port
    for (int p = 0; p < NPORT; p++)
    begin
      found = 1'b0;
      best = '0;
      pick_cls[p] = 2'h0;
      for (int k = 0; k < NCLS; k++)
        if (nonempty[p][k] && !discard[p][k] &&
            (s_q.ctrl[CTRL_STRICT] || !hd[p][k].ro || fwd[p][k]) &&
            (!found || age[p][k] > best))
        begin
          found = 1'b1;
          best = age[p][k];
          pick_cls[p] = 2'(k);
        end
      pick_ok[p] = found && fwd[p][pick_cls[p]];
    end
    // Egress arbiters
    for (int q = 0; q < NPORT; q++)
    begin
      g = 3'(NPORT);
      w = s_q.wrr[{s_q.phase[q], 1'b0} +: 2];
      if (s_q.ctrl[CTRL_WRR] && 32'(w) < NPORT && pick_ok[w] &&
          32'(hd[w][pick_cls[w]].dest) == q)
        g = {1'b0, w};
      for (int k = 1; k <= NPORT; k++)
      begin
        idx = (32'(s_q.rr_last[q]) + k) % NPORT;
        if (g == 3'(NPORT) && pick_ok[idx] && 32'(hd[idx][pick_cls[idx]].dest) == q)
          g = 3'(idx);
      end
      if (g != 3'(NPORT))
      begin
        c = pick_cls[g[1:0]];
        pop[g[1:0]][c] = 1'b1;
        s_d.e_valid[q] = 1'b1;
        s_d.e_src[q] = g[1:0];
        s_d.e_cls[q] = c;
        s_d.e_len[q] = hd[g[1:0]][c].len;
        s_d.e_id[q] = hd[g[1:0]][c].id;
        s_d.e_keep[q] = hd[g[1:0]][c].keep;
        s_d.rr_last[q] = g[1:0];
        s_d.phase[q] = 5'(s_q.phase[q] + 1'b1);
      end
    end
    // Pops release descriptors and credits
    for (int p = 0; p < NPORT; p++)
      for (int k = 0; k < NCLS; k++)
        if (pop[p][k] || discard[p][k])
        begin
          s_d.rd[p][k] = IW'(s_q.rd[p][k] + 1'b1);
          s_d.cnt[p][k] = CW'(s_q.cnt[p][k] - 1'b1);
          s_d.hdr_used[p][k] = 8'(s_q.hdr_used[p][k] - 1'b1);
          s_d.dat_used[p][k] = 12'(s_q.dat_used[p][k] - dcred(2'(k), hd[p][k].len));
          if (discard[p][k])
            s_d.drops = 16'(s_d.drops + 1'b1);
        end
    // Link events
    for (int p = 0; p < NPORT; p++)
    begin
      if (s_q.link_q[p] && !link_up[p])
        for (int k = 0; k < NCLS; k++)
          for (int i = 0; i < DEPTH; i++)
            if (!s_q.mem[p][k][i].keep)
              s_d.mem[p][k][i].drop = 1'b1;
      if (!s_q.link_q[p] && link_up[p])
      begin
        s_d.adv[p] = 1'b1;
        s_d.spl[p] = (p != 0);
      end
      if (tail_done[p])
        s_d.mem[p][s_q.last_cls[p]][IW'(s_q.wr[p][s_q.last_cls[p]] - 1'b1)].done = 1'b1;
    end
    s_d.link_q = link_up;
    // Ingress acceptance
    for (int p = 0; p < NPORT; p++)
    begin
      c = in_cls[p];
      dst = in_bridge[p] ? in_key[p] : s_q.route[{in_key[p], 1'b0} +: 2];
      ur_path[p] = !in_bridge[p] && (32'(dst) >= NPORT || !link_up[dst]);
      fits[p] = 1'b0;
      if (32'(c) < NCLS)
      begin
        dc = dcred(c, in_len[p]);
        gran = (c == CLS_NP) ? GRAN_NP : GRAN_BIG;
        lim_h = 8'(s_q.cred[c][p][7:0] + (in_gen[p] ? RSV_CRED : 8'h0));
        lim_d = 12'(s_q.cred[c][p][19:8] + (in_gen[p] ? {4'h0, RSV_CRED} : 12'h0));
        bytes = 17'((s_q.hdr_used[p][c] + 17'h1) * HDR_BYTES +
                    (s_q.dat_used[p][c] + dc) * gran);
        fits[p] = 32'(s_q.cnt[p][c]) < DEPTH &&
                  {1'b0, s_q.hdr_used[p][c]} + 9'h1 <= {1'b0, lim_h} &&
                  {1'b0, s_q.dat_used[p][c]} + {1'b0, dc} <= {1'b0, lim_d} &&
                  bytes <= FIFO_BYTES[c];
      end
      in_ready[p] = (link_up[p] || in_keep[p]) &&
                    (ur_path[p] ? !urtaken : fits[p]);
      s_d.hs_past[p] = in_valid[p] && in_ready[p];
      if (in_valid[p] && in_ready[p])
      begin
        if (ur_path[p])
        begin
          urtaken = 1'b1;
          s_d.ur_valid = 1'b1;
          s_d.ur_src = 2'(p);
          s_d.ur_id = in_id[p];
        end
        else
        begin
          s_d.mem[p][c][s_q.wr[p][c]] = '{dest: dst, len: in_len[p], ro: in_ro[p],
                                          keep: in_keep[p], done: in_done[p], drop: 1'b0,
                                          gen: in_gen[p], ts: s_q.ts, id: in_id[p]};
          s_d.wr[p][c] = IW'(s_q.wr[p][c] + 1'b1);
          s_d.cnt[p][c] = CW'(s_d.cnt[p][c] + 1'b1);
          s_d.hdr_used[p][c] = 8'(s_d.hdr_used[p][c] + 1'b1);
          s_d.dat_used[p][c] = 12'(s_d.dat_used[p][c] + dc);
          s_d.last_cls[p] = c;
        end
      end
    end
    // APB slave, zero wait states
    if (psel && !penable)
    begin
      s_d.prdata = reg_rdata;
      s_d.pslverr = !reg_hit;
    end
    if (psel && penable && pwrite && reg_hit)
    begin
      if (paddr == REG_CTRL)
        s_d.ctrl = pwdata[2:0];
      else if (paddr == REG_ROUTE)
        s_d.route = pwdata[7:0];
      else if (paddr == REG_WRR0)
        s_d.wrr[31:0] = pwdata;
      else if (paddr == REG_WRR1)
        s_d.wrr[63:32] = pwdata;
      else if (paddr >= REG_CRED && paddr < REG_SLOT)
        s_d.cred[2'(paddr[5:4] - 2'h1)][paddr[3:2]] = pwdata[19:0];
      else if (paddr[7:4] == REG_SLOT[7:4])
      begin
        s_d.slot[paddr[3:2]] = pwdata;
        if (paddr[3:2] != 2'h0 && link_up[paddr[3:2]])
          s_d.spl[paddr[3:2]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.ctrl <= CTRL_DEF;
      s_q.route <= ROUTE_DEF;
      s_q.wrr <= WRR_DEF;
      for (int k = 0; k < NCLS; k++)
        s_q.cred[k] <= {NPORT{CRED_DEF[k]}};
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // Outputs
  assign prdata = s_q.prdata;
  assign pready = 1'b1;
  assign pslverr = s_q.pslverr;
  assign e_valid = s_q.e_valid;
  assign e_src = s_q.e_src;
  assign e_cls = s_q.e_cls;
  assign e_len = s_q.e_len;
  assign e_id = s_q.e_id;
  assign e_keep = s_q.e_keep;
  assign ur_valid = s_q.ur_valid;
  assign ur_src = s_q.ur_src;
  assign ur_id = s_q.ur_id;
  assign adv_valid = s_q.adv;
  assign slot_power_msg = s_q.spl;
  assign slot_cap = s_q.slot;
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
      for (int k = 0; k < NCLS; k++)
      begin
        adv_hdr[p][k] = s_q.cred[k][p][7:0];
        adv_data[p][k] = s_q.cred[k][p][19:8];
      end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_UR_SRC: assert property (ur_valid |-> s_q.hs_past[ur_src])
    else $error("UR without an accepted ingress TLP");

  for (genvar q = 0; q < NPORT; q++)
  begin : g_eg
    AST_REPLAY: assert property (e_valid[q] |-> !$past(e_replay_full[q]))
      else $error("forwarded while replay buffer full");
    AST_CREDIT: assert property (e_valid[q] |-> s_q.cr_past[q][e_cls[q]])
      else $error("forwarded without partner credit");
    AST_FLUSH: assert property (e_valid[q] |-> s_q.link_q[e_src[q]] || e_keep[q])
      else $error("forwarded from a down ingress port");
    AST_ARB: assert property (e_valid[q] && e_valid[(q + 1) % NPORT] |->
                              e_src[q] != e_src[(q + 1) % NPORT])
      else $error("one ingress granted to two egress ports");
    AST_ADV: assert property ($rose(link_up[q]) |=> adv_valid[q] ##1 !adv_valid[q])
      else $error("credit advertisement missing at link up");
    if (q == 0)
    begin : g_up
      AST_SPL: assert property (!slot_power_msg[q])
        else $error("slot power message on upstream port");
    end
    else
    begin : g_dn
      AST_SPL: assert property ($rose(link_up[q]) |=> slot_power_msg[q])
        else $error("slot power message missing at link up");
    end
    for (genvar k = 0; k < NCLS; k++)
    begin : g_cl
      AST_AGE: assert property (s_q.cnt[q][k] != '0 && age[q][k] > AGE_LIMIT &&
                                !hd[q][k].keep |=> s_q.rd[q][k] != $past(s_q.rd[q][k]))
        else $error("stale head not discarded");
      AST_FULL: assert property (in_valid[q] && in_cls[q] == 2'(k) && !ur_path[q] &&
                                 32'(s_q.cnt[q][k]) == DEPTH |-> !in_ready[q])
        else $error("full queue accepted a TLP");
    end
  end
endmodule

//--- rtl/swc_pkg.sv
// Constants, register map and entry layout for the switch core fabric.
// Assumes one 100 MHz core clock and an APB register port.
package swc_pkg;
  // ==========================================================
  // Sizes and timing
  localparam int NPORT     = 3;
  localparam int NCLS      = 3;
  localparam int TS_W      = 16;
  localparam int CLK_NS    = 10;
  localparam int TICK_NS   = 1000;
  localparam int TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int AGE_MS    = 50;
  localparam int AGE_TICKS = AGE_MS * 1000000 / TICK_NS;
  localparam int DEPTH_DEF = 32;

  // ==========================================================
  // Traffic classes and buffer accounting
  localparam logic [1:0] CLS_P   = 2'h0;
  localparam logic [1:0] CLS_NP  = 2'h1;
  localparam logic [1:0] CLS_CPL = 2'h2;
  localparam logic [16:0] HDR_BYTES = 17'h00014;
  localparam logic [16:0] GRAN_BIG  = 17'h00010;
  localparam logic [16:0] GRAN_NP   = 17'h00008;
  localparam logic [NCLS-1:0][16:0] FIFO_BYTES = {17'h01000, 17'h00400, 17'h01000};
  localparam logic [7:0]  RSV_CRED  = 8'h02;
  localparam logic [NCLS-1:0][19:0] CRED_DEF = {20'h0CC1E, 20'h01E1E, 20'h0CC1E};

  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ROUTE = 8'h04;
  localparam logic [7:0] REG_WRR0  = 8'h08;
  localparam logic [7:0] REG_WRR1  = 8'h0C;
  localparam logic [7:0] REG_CRED  = 8'h10;
  localparam logic [7:0] REG_SLOT  = 8'h40;
  localparam logic [7:0] REG_STAT  = 8'h50;
  localparam logic [7:0] REG_DROPS = 8'h54;
  localparam int CTRL_STRICT = 0;
  localparam int CTRL_WRR    = 1;
  localparam int CTRL_HOLD   = 2;
  localparam logic [2:0]  CTRL_DEF  = 3'h0;
  localparam logic [7:0]  ROUTE_DEF = 8'hE4;
  localparam logic [63:0] WRR_DEF   = 64'h0;

  typedef struct packed {
    logic [1:0]      dest;
    logic [12:0]     len;
    logic            ro;
    logic            keep;
    logic            done;
    logic            drop;
    logic            gen;
    logic [TS_W-1:0] ts;
    logic [7:0]      id;
  } swc_entry_t;
endpackage

//--- test/pcie_switch_core_fabric_test.sv
// Bench for the switch core: APB master, ingress driver, egress stack model.
// Assumes the shortened age timer: TICK 2 cycles, AGE_LIMIT 20 ticks.
`timescale 1ns/1ns
module pcie_switch_core_fabric_test;
  import swc_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, hit, err;
  logic [7:0] paddr = 0, ur_id, seen;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0] ur_src;
  logic ur_valid;
  logic [2:0] link_up = 0, in_valid = 0, in_ready, e_valid, e_replay_full, e_keep, stall = 0;
  logic [2:0] adv_valid, slot_power_msg, adv_seen, spl_seen;
  logic [2:0] in_bridge = 0, in_keep = 0, in_gen = 0, in_done = 3'h7;
  logic [2:0][1:0] in_cls = 0, in_key = 0, e_src, e_cls;
  logic [2:0][12:0] in_len = '{default: 13'h0040}, e_len;
  logic [2:0][7:0] in_id = 0, e_id;
  logic [2:0][2:0] e_credit_ok;
  logic [2:0][2:0][7:0] adv_hdr;
  logic [2:0][2:0][11:0] adv_data;
  logic [2:0][31:0] slot_cap;
  logic [9:0] ur_last;
  int errors = 0, checks = 0;
  always #5 clk = ~clk;
  always @(negedge clk)
  begin
    adv_seen |= adv_valid;
    spl_seen |= slot_power_msg;
    if (ur_valid === 1'b1)
      ur_last = {ur_src, ur_id};
  end
  swc_core #(.AGE_LIMIT(16'h0014), .TICK(12'h002)) i_swc_core (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_up(link_up),
    .link_width(9'h124), .in_valid(in_valid), .in_ready(in_ready), .in_cls(in_cls),
    .in_key(in_key), .in_bridge(in_bridge), .in_len(in_len), .in_ro(3'h0),
    .in_keep(in_keep), .in_gen(in_gen), .in_done(in_done), .in_id(in_id), .tail_done(3'h0),
    .e_credit_ok(e_credit_ok), .e_replay_full(e_replay_full), .e_valid(e_valid),
    .e_src(e_src), .e_cls(e_cls), .e_len(e_len), .e_id(e_id), .e_keep(e_keep),
    .ur_valid(ur_valid), .ur_src(ur_src), .ur_id(ur_id), .adv_valid(adv_valid),
    .adv_hdr(adv_hdr), .adv_data(adv_data), .slot_power_msg(slot_power_msg),
    .slot_cap(slot_cap));
  swc_stack_model i_swc_stack_model (.clk(clk), .rst_n(rst_n), .stall(stall),
    .e_valid(e_valid), .e_credit_ok(e_credit_ok), .e_replay_full(e_replay_full), .seen(seen));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 50);
    if (n == 50)
      errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input int p, input logic [1:0] k, input logic [7:0] id);
    int n = 0;
    @(posedge clk);
    in_valid[p] <= 1'b1;
    in_key[p] <= k;
    in_id[p] <= id;
    do
      @(posedge clk);
    while (in_ready[p] !== 1'b1 && ++n < 50);
    if (n == 50)
      errors++;
    in_valid[p] <= 1'b0;
  endtask
  task automatic wait_e(input int q, input int lim);
    hit = 1'b0;
    repeat (lim)
    begin
      @(negedge clk);
      if (e_valid[q] === 1'b1)
        return;
    end
    hit = 1'b0;
  endtask
  task automatic fwd(input int p, input logic [1:0] k, input int q, input logic [7:0] id);
    send(p, k, id);
    wait_e(q, 20);
    chk(32'(e_valid[q]), 32'h1);
    chk(32'({e_src[q], e_id[q]}), 32'({2'(p), id}));
    chk(32'({e_cls[q], e_len[q]}), 32'({CLS_P, 13'h0040}));
  endtask
  task automatic t_regs;
    chk(32'({adv_hdr[0][0], adv_data[0][0], adv_data[0][1]}), 32'h1E0CC01E);
    apb(1'b0, REG_ROUTE, 32'h0);
    chk(rd, 32'h000000E4);
    apb(1'b0, 8'h5C, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, REG_CTRL, 32'h00000004);
    apb(1'b1, REG_CRED, 32'h0000C01C);
    apb(1'b1, REG_CTRL, 32'h00000000);
  endtask
  task automatic t_link;
    adv_seen = 0;
    spl_seen = 0;
    link_up <= 3'h7;
    repeat (5) @(posedge clk);
    chk(32'({adv_seen, spl_seen, adv_hdr[0][0]}), 32'h00003E1C);
    spl_seen = 0;
    apb(1'b1, REG_SLOT + 8'h04, 32'h00000123);
    repeat (3) @(posedge clk);
    chk(32'(spl_seen), 32'h2);
    chk(slot_cap[1], 32'h00000123);
  endtask
  task automatic t_stall(input int ms, input logic [31:0] drops);
    stall[1] <= 1'b1;
    send(0, 2'h1, 8'h33);
    repeat (ms) @(posedge clk);
    stall[1] <= 1'b0;
    wait_e(1, 20);
    chk(32'(e_valid[1]), 32'(ms < 40));
    apb(1'b0, REG_DROPS, 32'h0);
    chk(rd, drops);
  endtask
  task automatic t_down;
    stall[0] <= 1'b1;
    send(1, 2'h0, 8'h66);
    link_up[1] <= 1'b0;
    repeat (5) @(posedge clk);
    stall[0] <= 1'b0;
    wait_e(0, 15);
    chk(32'(e_valid[0]), 32'h0);
    apb(1'b0, REG_DROPS, 32'h0);
    chk(rd, 32'h2);
    link_up[2] <= 1'b0;
    send(0, 2'h2, 8'h55);
    repeat (3) @(posedge clk);
    chk(32'(ur_last), 32'h055);
    // Kept TLP on a down port, then bridge access to a down port
    in_keep[1] <= 1'b1;
    in_bridge[0] <= 1'b1;
    fwd(1, 2'h0, 0, 8'h44);
    chk(32'(e_keep[0]), 32'h1);
    fwd(0, 2'h2, 2, 8'h77);
    @(posedge clk);
    in_bridge[0] <= 1'b0;
    in_keep[1] <= 1'b0;
  endtask
  initial
  begin
    #200000;
    errors++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_link;
    fwd(0, 2'h1, 1, 8'h11);
    fwd(1, 2'h1, 1, 8'h22);
    t_stall(12, 32'h0);
    t_stall(120, 32'h1);
    t_down;
    end_sim;
  end
endmodule

//--- test/swc_stack_model.sv
// Egress stack model: grants credit, raises replay-full on stall, counts TLPs.
// Assumes e_valid pulses once per forwarded TLP.
`timescale 1ns/1ns
module swc_stack_model (
  input  wire logic                                       clk,
  input  wire logic                                       rst_n,
  input  wire logic [swc_pkg::NPORT-1:0]                  stall,
  input  wire logic [swc_pkg::NPORT-1:0]                  e_valid,
  output logic      [swc_pkg::NPORT-1:0][swc_pkg::NCLS-1:0] e_credit_ok,
  output logic      [swc_pkg::NPORT-1:0]                  e_replay_full,
  output logic      [7:0]                                 seen
);
  import swc_pkg::*;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      e_credit_ok   <= '0;
      e_replay_full <= '0;
      seen          <= 8'h00;
    end
    else
    begin
      e_credit_ok   <= '1;
      e_replay_full <= stall;
      seen          <= seen + 8'(e_valid[0]) + 8'(e_valid[1]) + 8'(e_valid[2]);
    end
  end
endmodule
